// ==== design/lpmc_top.sv ====
// low-power mode control with ahb-lite register slave
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "lpmc_defs.svh"
module lpmc_top import lpmc_pkg::*; #(
    parameter int NIRQ        = 4,
    parameter int HOLD_W      = 16,
    parameter int QUEUE_DEPTH = 4
) (
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                nmi_n,
    input  wire logic                voltMonIrq,
    input  wire logic [NIRQ-1:0]     irqReq,
    input  wire logic [3*NIRQ-1:0]   irqLevel,
    input  wire logic [2*NIRQ-1:0]   irqClass,
    input  wire logic [NIRQ-1:0]     irqStopOk,
    input  wire logic                adcDoneIrq,
    input  wire logic [2:0]          adcLevel,
    input  wire logic                adcOneShot,
    input  wire logic                subClkTick,
    input  wire logic                extBusMode,
    input  wire logic [HOLD_W-1:0]   heldPinsIn,
    input  wire logic                rdStrobeIn_n,
    input  wire logic                wrStrobeIn_n,
    input  wire logic                holdAckIn_n,
    input  wire logic                busClkIn,
    input  wire logic                latchEnIn,
    output logic                     cpuClkEn,
    output logic                     watchdogEn,
    output logic                     converterEn,
    output logic                     periphEnDiv1,
    output logic                     periphEnDiv8,
    output logic                     periphEnDiv32,
    output logic                     ungatedDivEn,
    output logic                     subclockDiv32En,
    output logic                     mainOscRun,
    output logic                     subOscRun,
    output logic                     onchipOscRun,
    output logic      [HOLD_W-1:0]   heldPinsOut,
    output logic                     rdStrobe_n,
    output logic                     wrStrobe_n,
    output logic                     holdAck_n,
    output logic                     busClk,
    output logic                     latchEn,
    output logic                     clockOutputPin,
    output logic                     mainXinHiZ,
    output logic                     mainXoutHigh,
    output logic                     subXtalHiZ,
    output logic                     irqEntry,
    output logic      [4:0]          cpuClkDivision
);
    localparam int QW = $clog2(QUEUE_DEPTH + 1);

    function automatic logic [7:0] wrMask(input logic [3:0] idx);
        unique case (idx)
            `LPMC_IDX_CCR0: wrMask = `LPMC_M_CCR0;
            `LPMC_IDX_CCR1: wrMask = `LPMC_M_CCR1;
            `LPMC_IDX_CCR2: wrMask = `LPMC_M_CCR2;
            `LPMC_IDX_PM2:  wrMask = `LPMC_M_PM2;
            `LPMC_IDX_PRCR: wrMask = `LPMC_M_PRCR;
            `LPMC_IDX_MCD:  wrMask = `LPMC_M_MCD;
            `LPMC_IDX_CMD,
            `LPMC_IDX_STAT: wrMask = 8'h00;
            default:        wrMask = 8'hff;
        endcase
    endfunction

    function automatic logic [7:0] lockMask(input logic [3:0] idx);
        unique case (idx)
            `LPMC_IDX_CCR0: lockMask = `LPMC_L_CCR0;
            `LPMC_IDX_CCR1: lockMask = `LPMC_L_CCR1;
            `LPMC_IDX_CCR2: lockMask = `LPMC_L_CCR2;
            `LPMC_IDX_PLL:  lockMask = 8'hff;
            default:        lockMask = 8'h00;
        endcase
    endfunction

    function automatic logic protOk(input logic [3:0] idx,
                                    input logic [7:0] prcr);
        unique case (idx)
            `LPMC_IDX_CCR0, `LPMC_IDX_CCR1, `LPMC_IDX_CCR2,
            `LPMC_IDX_PLL, `LPMC_IDX_MCD:
                protOk = prcr[`LPMC_B_CLOCK_REG_WRITE_ENABLE];
            `LPMC_IDX_PM0, `LPMC_IDX_PM1, `LPMC_IDX_PM2:
                protOk = prcr[`LPMC_B_MODE_REG_WRITE_ENABLE];
            `LPMC_IDX_PDIR:
                protOk = prcr[`LPMC_B_PORT_DIR_WRITE_ENABLE];
            default:
                protOk = 1'b1;
        endcase
    endfunction

    function automatic logic levelOn(input logic [2:0] lvl);
        levelOn = (lvl != 3'h0);
    endfunction

    lpmc_state_t    state_reg, state_next;
    logic [7:0]     regs_reg [`LPMC_NREG];
    logic [7:0]     regs_next [`LPMC_NREG];
    logic           wrPend_reg, wrPend_next;
    logic [3:0]     wrIdx_reg, wrIdx_next;
    logic [31:0]    rdData_reg, rdData_next;
    logic [QW-1:0]  drain_reg, drain_next;
    logic           irqEntry_reg, irqEntry_next;
    logic [2:0]     wake_reg, wake_next;
    logic [HOLD_W-1:0] held_reg, held_next;
    logic           clock_output_pin_reg, clock_output_pin_next;
    logic           addrOk, mapped, gating, lock, divX;
    logic           stopSet, waitCmd, wakeWait, stopWake;
    logic           periphWake, periphStop, adcWake;
    logic [4:0]     gateVec, clkEnVec;
    logic [1:0]     clkSel;
    logic [7:0]     keep, newVal;

    assign gating = regs_reg[`LPMC_IDX_CCR0][`LPMC_B_GATE];
    assign lock   = regs_reg[`LPMC_IDX_PM2][`LPMC_B_LOCK];
    assign divX   = regs_reg[`LPMC_IDX_CCR2][`LPMC_B_DIVX];
    assign clkSel = regs_reg[`LPMC_IDX_CCR0][1:0];

    // bus slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdData_reg;
    assign addrOk    = hsel & htrans[1] & hready;
    assign mapped    = (haddr[31:6] == 26'h0) && (haddr[5:2] < 4'hc);

    always_comb begin
        wrPend_next = addrOk & hwrite & mapped;
        wrIdx_next  = haddr[5:2];
        rdData_next = rdData_reg;
        if (addrOk && !hwrite) begin
            rdData_next = 32'h0;
            if (haddr[5:2] == `LPMC_IDX_STAT) begin
                rdData_next = {27'h0, wake_reg, state_reg};
            end else if (mapped && haddr[5:2] != `LPMC_IDX_CMD) begin
                rdData_next = {24'h0, regs_reg[haddr[5:2]]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wrPend_reg <= 1'b0;
            wrIdx_reg  <= 4'h0;
            rdData_reg <= 32'h0;
        end else begin
            wrPend_reg <= wrPend_next;
            wrIdx_reg  <= wrIdx_next;
            rdData_reg <= rdData_next;
        end
    end

    // wake qualification
    always_comb begin
        periphWake = 1'b0;
        periphStop = 1'b0;
        for (int i = 0; i < NIRQ; i++) begin
            if (irqReq[i] && levelOn(irqLevel[3*i +: 3])) begin
                unique case (lpmc_clk_class_t'(irqClass[2*i +: 2]))
                    LPMC_CK_GATED: periphWake |= !gating;
                    LPMC_CK_EXT,
                    LPMC_CK_SUB32: periphWake = 1'b1;
                    LPMC_CK_DIVX:  periphWake |= !gating | divX;
                endcase
                periphStop |= irqStopOk[i];
            end
        end
    end

    assign adcWake  = adcDoneIrq & levelOn(adcLevel)
                      & !gating & adcOneShot;
    assign wakeWait = !nmi_n | voltMonIrq | periphWake | adcWake;
    assign stopWake = !nmi_n | voltMonIrq | periphStop;
    assign waitCmd  = wrPend_reg && wrIdx_reg == `LPMC_IDX_CMD
                      && hwdata[`LPMC_B_WAIT];
    assign stopSet  = !regs_reg[`LPMC_IDX_CCR1][`LPMC_B_STOP]
                      && regs_next[`LPMC_IDX_CCR1][`LPMC_B_STOP];

    // register file
    always_comb begin
        regs_next = regs_reg;
        keep      = ~wrMask(wrIdx_reg)
                    | (lock ? lockMask(wrIdx_reg) : 8'h00);
        newVal    = (regs_reg[wrIdx_reg] & keep) | (hwdata[7:0] & ~keep);
        if (wrPend_reg && protOk(wrIdx_reg, regs_reg[`LPMC_IDX_PRCR])) begin
            regs_next[wrIdx_reg] = newVal;
        end
        // stop bit only takes while nmi is released
        if (!nmi_n) begin
            regs_next[`LPMC_IDX_CCR1][`LPMC_B_STOP] =
                regs_reg[`LPMC_IDX_CCR1][`LPMC_B_STOP];
        end
        if (wrPend_reg && wrIdx_reg != `LPMC_IDX_PRCR) begin
            regs_next[`LPMC_IDX_PRCR][`LPMC_B_PORT_DIR_WRITE_ENABLE] = 1'b0;
        end
        if (!regs_reg[`LPMC_IDX_CCR1][`LPMC_B_STOP]
            && regs_next[`LPMC_IDX_CCR1][`LPMC_B_STOP]) begin
            regs_next[`LPMC_IDX_MCD] = `LPMC_MCD_DIV8;
        end
        if (state_reg == LPMC_STOP && stopWake) begin
            regs_next[`LPMC_IDX_CCR1][`LPMC_B_STOP] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            for (int i = 0; i < `LPMC_NREG; i++) begin
                regs_reg[i] <= 8'h00;
            end
            regs_reg[`LPMC_IDX_MCD] <= `LPMC_MCD_RST;
        end else begin
            regs_reg <= regs_next;
        end
    end

    // power state machine; division register is never touched on wake
    always_comb begin
        state_next    = state_reg;
        drain_next    = drain_reg;
        irqEntry_next = 1'b0;
        wake_next     = wake_reg;
        unique case (state_reg)
            LPMC_RUN: begin
                if (stopSet) begin
                    state_next = LPMC_STOP;
                end else if (waitCmd && !lock) begin
                    state_next = LPMC_WAIT;
                end
            end
            LPMC_WAIT: begin
                if (wakeWait) begin
                    state_next    = LPMC_RUN;
                    irqEntry_next = 1'b1;
                    wake_next     = {periphWake | adcWake, voltMonIrq, !nmi_n};
                end
            end
            LPMC_STOP: begin
                if (stopWake) begin
                    state_next = LPMC_DRAIN;
                    drain_next = QW'(QUEUE_DEPTH - 1);
                    wake_next  = {periphStop, voltMonIrq, !nmi_n};
                end
            end
            LPMC_DRAIN: begin
                // queued instructions retire before the handler starts
                if (drain_reg == '0) begin
                    state_next    = LPMC_RUN;
                    irqEntry_next = 1'b1;
                end else begin
                    drain_next = drain_reg - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_reg    <= LPMC_RUN;
            drain_reg    <= '0;
            irqEntry_reg <= 1'b0;
            wake_reg     <= 3'h0;
        end else begin
            state_reg    <= state_next;
            drain_reg    <= drain_next;
            irqEntry_reg <= irqEntry_next;
            wake_reg     <= wake_next;
        end
    end

    assign irqEntry       = irqEntry_reg;
    assign cpuClkDivision = regs_reg[`LPMC_IDX_MCD][4:0];

    // clock enables
    assign cpuClkEn   = (state_reg == LPMC_RUN) || (state_reg == LPMC_DRAIN);
    assign watchdogEn = cpuClkEn || (state_reg == LPMC_WAIT
                        && regs_reg[`LPMC_IDX_PM2][`LPMC_B_WDSRC]);
    assign gateVec    = {(state_reg == LPMC_WAIT) & gating & !divX,
                         {4{(state_reg == LPMC_WAIT) & gating}}};

    lpmc_clk_gate #(
        .N (5)
    ) u_gate (
        .clk_sys    (clk_sys),
        .rstn       (rstn),
        .runEn      (state_reg != LPMC_STOP),
        .gateVec    (gateVec),
        .subClkTick (subClkTick),
        .clkEn      (clkEnVec),
        .subDiv32En (subclockDiv32En)
    );

    assign periphEnDiv1  = clkEnVec[0];
    assign periphEnDiv8  = clkEnVec[1];
    assign periphEnDiv32 = clkEnVec[2];
    assign converterEn   = clkEnVec[3];
    assign ungatedDivEn  = clkEnVec[4];

    // oscillators run in wait and stop in stop; the main one also stops on its mstop bit
    assign mainOscRun   = (state_reg != LPMC_STOP)
                          && !regs_reg[`LPMC_IDX_CCR0][`LPMC_B_MSTOP];
    assign subOscRun    = (state_reg != LPMC_STOP);
    assign onchipOscRun = (state_reg != LPMC_STOP);
    assign mainXinHiZ   = (state_reg == LPMC_STOP);
    assign mainXoutHigh = (state_reg == LPMC_STOP);
    assign subXtalHiZ   = (state_reg == LPMC_STOP);

    // pin hold; strobes are forced only on an external bus
    always_comb begin
        held_next = held_reg;
        if (cpuClkEn) begin
            held_next = heldPinsIn;
        end
    end

    always_comb begin
        clock_output_pin_next = clock_output_pin_reg;
        unique case (clkSel)
            2'h0: clock_output_pin_next = 1'b0;
            2'h1: begin
                if (state_reg == LPMC_STOP) begin
                    clock_output_pin_next = 1'b1;
                end else if (subClkTick) begin
                    clock_output_pin_next = !clock_output_pin_reg;
                end
            end
            2'h2: clock_output_pin_next = clock_output_pin_reg ^ periphEnDiv8;
            2'h3: clock_output_pin_next = clock_output_pin_reg ^ periphEnDiv32;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            held_reg   <= '0;
            clock_output_pin_reg <= 1'b0;
        end else begin
            held_reg   <= held_next;
            clock_output_pin_reg <= clock_output_pin_next;
        end
    end

    assign heldPinsOut    = held_reg;
    assign clockOutputPin = clock_output_pin_reg;
    assign rdStrobe_n = (extBusMode && !cpuClkEn) | rdStrobeIn_n;
    assign wrStrobe_n = (extBusMode && !cpuClkEn) | wrStrobeIn_n;
    assign holdAck_n  = (extBusMode && !cpuClkEn) | holdAckIn_n;
    assign busClk     = (extBusMode && !cpuClkEn) | busClkIn;
    always_comb begin
        latchEn = latchEnIn;
        if (extBusMode && state_reg == LPMC_WAIT) begin
            latchEn = 1'b0;
        end else if (extBusMode && state_reg == LPMC_STOP) begin
            latchEn = 1'b1;
        end
    end

    stop_entry_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state_reg == LPMC_RUN && stopSet) |=> (state_reg == LPMC_STOP
        && cpuClkDivision == 5'h08)) else $error("stop entry wrong");
    wait_gated_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state_reg == LPMC_WAIT && gating) |-> (!periphEnDiv1 && !converterEn
        && !periphEnDiv8 && !periphEnDiv32)) else $error("gating leak");
    wdog_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state_reg == LPMC_WAIT) |-> (watchdogEn
        == regs_reg[`LPMC_IDX_PM2][`LPMC_B_WDSRC])) else $error("wdog");
    stop_halt_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state_reg == LPMC_STOP) |-> (!cpuClkEn && !periphEnDiv8
        && !ungatedDivEn && !subclockDiv32En)) else $error("clk in stop");
    lock_pll_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (wrPend_reg && lock && wrIdx_reg == `LPMC_IDX_PLL) |=>
        $stable(regs_reg[`LPMC_IDX_PLL])) else $error("pll written");
    port_dir_write_enable_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (wrPend_reg && wrIdx_reg != `LPMC_IDX_PRCR) |=>
        !regs_reg[`LPMC_IDX_PRCR][`LPMC_B_PORT_DIR_WRITE_ENABLE]) else $error("port_dir_write_enable");
    lock_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state_reg == LPMC_RUN && waitCmd && lock) |=> cpuClkEn)
        else $error("wait under lock");
    bus_pins_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state_reg == LPMC_WAIT && extBusMode) |-> (rdStrobe_n && busClk
        && wrStrobe_n && holdAck_n && !latchEn))
        else $error("bus pins");
    // the last running value is captured on the edge into wait, so check
    // that nothing moves from one halted cycle to the next
    pins_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !cpuClkEn |=> $stable(heldPinsOut))
        else $error("pins moved");
    stop_exit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state_reg == LPMC_STOP && stopWake) |=> (cpuClkEn && !irqEntry)
        ##[1:16] irqEntry) else $error("stop exit");
    clock_output_pin_sub_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state_reg == LPMC_STOP && clkSel == 2'h1) |=> clockOutputPin)
        else $error("clock pin in stop");
    level_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (state_reg == LPMC_WAIT && nmi_n && !voltMonIrq && !adcDoneIrq
        && irqLevel == '0) |=> (state_reg == LPMC_WAIT))
        else $error("disabled wake");

    wait_cycle_c: cover property (@(posedge clk_sys) disable iff (!rstn)
        state_reg == LPMC_WAIT ##[1:50] irqEntry);
    stop_cycle_c: cover property (@(posedge clk_sys) disable iff (!rstn)
        state_reg == LPMC_STOP ##[1:50] state_reg == LPMC_DRAIN);
    port_dir_write_enable_use_c: cover property (@(posedge clk_sys) disable iff (!rstn)
        regs_reg[`LPMC_IDX_PRCR][`LPMC_B_PORT_DIR_WRITE_ENABLE] ##[1:20] wrPend_reg);
endmodule // lpmc_top

// ==== design/lpmc_defs.svh ====
// constants for the low-power mode control block
//
// How it works
// - wait halts cpu and watchdog; watchdog keeps counting if its source bit is 1
// - main, sub and on-chip oscillators keep running in wait; the main one stops when its mstop bit is set
// - gating bit 1 stops converter, div1, div8, div32 and selected divided clock in wait
// - sub div32 clock never gated in wait; crystal or on-chip divided clock ungated in wait only with divx bit set
// - wait with external bus: hold bus and ports, strobes high, latch low
// - wait: clock pin toggles for sub clock; div8/div32 only when ungated
// - wait ends on reset, nmi, voltage monitor or enabled peripheral interrupt
// - priority level 000b means disabled and never wakes
// - with gating, only external, sub div32 or ungated divided clock sources wake
// - wake from wait keeps cpu clock source and division unchanged
// - converter done wakes only ungated and in one-shot or single-sweep
// - timer wakes always ungated; gated only in event count or ungated source
// - serial wakes gated only with external or ungated divided clock
// - stop halts every clock, cpu and peripherals
// - writing 1 to all-clocks-stop with nmi high enters stop
// - setting all-clocks-stop forces cpu division to 01000b
// - queued instructions run before the wake handler after stop
// - stop: clock pin high for sub clock, frozen otherwise; latch enable high on an external bus
// - stop: main crystal in and sub crystal pins high-z, crystal out high
// - stop ends on reset, nmi, voltage monitor, key, external or slow timer
// - clock lock ignores writes to listed clock bits and whole pll register
// - wait under clock lock keeps the cpu clock running
// - port direction enable clears itself on the next write to another register
// - other protect enables change only when written
// - clock register writes need the clock write enable
// - mode register writes need the mode write enable
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH
`define LPMC_NREG      12
`define LPMC_IDX_CCR0  4'h0
`define LPMC_IDX_CCR1  4'h1
`define LPMC_IDX_CCR2  4'h2
`define LPMC_IDX_PLL   4'h3
`define LPMC_IDX_PM0   4'h4
`define LPMC_IDX_PM1   4'h5
`define LPMC_IDX_PM2   4'h6
`define LPMC_IDX_PRCR  4'h7
`define LPMC_IDX_MCD   4'h8
`define LPMC_IDX_CMD   4'h9
`define LPMC_IDX_STAT  4'ha
`define LPMC_IDX_PDIR  4'hb
`define LPMC_B_GATE    2
`define LPMC_B_MSTOP   5
`define LPMC_B_STOP    0
`define LPMC_B_DIVX    4
`define LPMC_B_LOCK    1
`define LPMC_B_WDSRC   2
`define LPMC_B_CLOCK_REG_WRITE_ENABLE    0
`define LPMC_B_MODE_REG_WRITE_ENABLE    1
`define LPMC_B_PORT_DIR_WRITE_ENABLE    2
`define LPMC_B_WAIT    0
`define LPMC_M_CCR0    8'ha7
`define LPMC_M_CCR1    8'h81
`define LPMC_M_CCR2    8'h13
`define LPMC_M_PM2     8'h06
`define LPMC_M_PRCR    8'h0f
`define LPMC_M_MCD     8'h1f
`define LPMC_L_CCR0    8'ha4
`define LPMC_L_CCR1    8'h81
`define LPMC_L_CCR2    8'h01
`define LPMC_MCD_RST   8'h12
`define LPMC_MCD_DIV8  8'h08
`define LPMC_DIV8_LAST 3'h7
`define LPMC_DIV32_LAST 5'h1f
`endif

// ==== design/lpmc_pkg.sv ====
// types for the low-power mode control block
package lpmc_pkg;
    typedef enum logic [1:0] {LPMC_RUN, LPMC_WAIT, LPMC_STOP, LPMC_DRAIN}
        lpmc_state_t;
    typedef enum logic [1:0] {LPMC_CK_GATED, LPMC_CK_EXT, LPMC_CK_SUB32,
                              LPMC_CK_DIVX} lpmc_clk_class_t;
endpackage

// ==== design/lpmc_clk_gate.sv ====
// peripheral clock enable divider with wait-mode gating
`timescale 1ns/1ps
`include "lpmc_defs.svh"
module lpmc_clk_gate #(
    parameter int N = 5
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic         runEn,
    input  wire logic [N-1:0] gateVec,
    input  wire logic         subClkTick,
    output logic      [N-1:0] clkEn,
    output logic              subDiv32En
);
    logic [4:0]   cnt_reg, cnt_next;
    logic [4:0]   subCnt_reg, subCnt_next;
    logic [N-1:0] raw;

    // order: div1, div8, div32, converter, divided clock
    assign raw = {cnt_reg[0], 1'b1, cnt_reg == `LPMC_DIV32_LAST,
                  cnt_reg[2:0] == `LPMC_DIV8_LAST, 1'b1};

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_en
            assign clkEn[i] = raw[i] & runEn & ~gateVec[i];
        end
    endgenerate

    // sub div32 ignores gating, only stop halts it
    assign subDiv32En = runEn & subClkTick
                        & (subCnt_reg == `LPMC_DIV32_LAST);

    always_comb begin
        cnt_next    = cnt_reg;
        subCnt_next = subCnt_reg;
        if (runEn) begin
            cnt_next = cnt_reg + 5'h01;
            if (subClkTick) begin
                subCnt_next = subCnt_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_reg    <= 5'h00;
            subCnt_reg <= 5'h00;
        end else begin
            cnt_reg    <= cnt_next;
            subCnt_reg <= subCnt_next;
        end
    end
endmodule // lpmc_clk_gate

// ==== verification/lpmc_tb.sv ====
// self-checking bench for the low-power mode control block
`timescale 1ns/1ps
module testbench;
logic        clk_sys = 0, rstn = 0, hsel = 0, hwrite = 0, hready;
logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
logic [1:0]  htrans = 0, irqClass = 0;
logic [2:0]  hsize = 3'h2, irqLevel = 0, adcLevel = 3'h0;
logic        nmi_n = 1, voltMonIrq = 0, irqReq = 0, extBusMode = 0;
logic        irqStopOk = 0, adcDoneIrq = 0, adcOneShot = 0, subClkTick;
logic        rdStrobeIn_n, wrStrobeIn_n, holdAckIn_n, busClkIn, latchEnIn;
logic [15:0] heldPinsIn, heldPinsOut, h;
logic        hreadyout, hresp, cpuClkEn, watchdogEn, converterEn;
logic        periphEnDiv1, periphEnDiv8, periphEnDiv32, ungatedDivEn;
logic        subclockDiv32En, mainOscRun, subOscRun, onchipOscRun, busClk;
logic        rdStrobe_n, wrStrobe_n, holdAck_n, latchEn, clockOutputPin;
logic        mainXinHiZ, mainXoutHigh, subXtalHiZ, irqEntry;
logic [4:0]  cpuClkDivision;
int          num_errors = 0, tests_run = 0, cyc = 0;
// core-side pins keep moving so frozen outputs are really seen frozen
assign hready = hreadyout;
assign heldPinsIn = cyc[15:0];
assign subClkTick = cyc[3:0] == 4'h0;
assign {latchEnIn, holdAckIn_n, wrStrobeIn_n, rdStrobeIn_n} = cyc[4:1];
assign busClkIn = cyc[0];
lpmc_top #(.NIRQ(1)) i_lpmc_top (.*);
always #4 clk_sys = ~clk_sys;
always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        num_errors++;
        summarize();
    end
end
task summarize;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
task chk(input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
        num_errors++;
        $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
endtask
// one single transfer; read data taken at the edge ending the data phase
task bus(input logic w, input logic [31:0] a, d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
endtask
task t_prot;
    bus(1, 32'h0, 32'h4); bus(0, 32'h0, 0); chk(r, 0);
    bus(1, 32'h1c, 32'h1); bus(1, 32'h0, 32'h4);
    bus(0, 32'h0, 0); chk(r, 32'h4);
    bus(0, 32'h40, 0); chk(r, 0);
endtask
task t_wait;
    irqLevel <= 3'h1;
    extBusMode <= 1;
    bus(1, 32'h24, 32'h1);
    @(posedge clk_sys);
    h = heldPinsOut;
    irqReq <= 1;
    repeat (3) @(posedge clk_sys);
    chk(heldPinsOut, h);
    chk({rdStrobe_n, wrStrobe_n, holdAck_n, busClk, latchEn, cpuClkEn},
        6'h3c);
    chk({watchdogEn, converterEn, periphEnDiv1, ungatedDivEn, mainOscRun,
        subOscRun, onchipOscRun}, 7'h07);
    bus(0, 32'h28, 0); chk(r[1:0], 2'h1);
    // divided clock from the selected source is gated as well
    irqClass <= 2'h3;
    repeat (2) @(posedge clk_sys);
    bus(0, 32'h28, 0); chk(r[1:0], 2'h1);
    irqClass <= 2'h1;
    repeat (2) @(posedge clk_sys);
    bus(0, 32'h28, 0); chk(r[4:0], 5'h10);
    irqReq <= 0;
    irqLevel <= 0;
    extBusMode <= 0;
    bus(1, 32'h24, 32'h1);
    irqReq <= 1;
    repeat (3) @(posedge clk_sys);
    bus(0, 32'h28, 0); chk(r[1:0], 2'h1);
    voltMonIrq <= 1;
    repeat (2) @(posedge clk_sys);
    bus(0, 32'h28, 0); chk(r[1:0], 2'h0);
    voltMonIrq <= 0;
    irqReq <= 0;
endtask
task t_lock;
    bus(1, 32'h1c, 32'h3); bus(1, 32'h18, 32'h2); bus(1, 32'h0, 32'h0);
    bus(0, 32'h0, 0); chk(r, 32'h4);
    bus(1, 32'h24, 32'h1); bus(0, 32'h28, 0); chk(r[1:0], 2'h0);
    bus(1, 32'h18, 32'h0);
endtask
task t_stop;
    nmi_n <= 0;
    bus(1, 32'h4, 32'h1); bus(0, 32'h28, 0); chk(r[1:0], 2'h0);
    nmi_n <= 1;
    bus(1, 32'h4, 32'h1);
    @(posedge clk_sys);
    chk({cpuClkEn, mainXinHiZ, mainXoutHigh, subXtalHiZ}, 4'h7);
    chk({mainOscRun, subOscRun, onchipOscRun, watchdogEn, ungatedDivEn,
        subclockDiv32En}, 6'h00);
    bus(0, 32'h20, 0); chk(r[4:0], 5'h08);
    nmi_n <= 0;
    for (int i = 0; i < 20 && irqEntry !== 1'b1; i++) @(posedge clk_sys);
    chk(irqEntry, 1);
    nmi_n <= 1;
    bus(0, 32'h28, 0); chk(r[4:0], 5'h04);
endtask
task t_pdir;
    bus(1, 32'h1c, 32'h7); bus(1, 32'h2c, 32'h55);
    bus(0, 32'h2c, 0); chk(r, 32'h55);
    bus(1, 32'h2c, 32'haa); bus(0, 32'h2c, 0); chk(r, 32'h55);
    bus(0, 32'h1c, 0); chk(r, 32'h3);
endtask
initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1;
    t_prot();
    t_wait();
    t_lock();
    t_stop();
    t_pdir();
    summarize();
end
endmodule // testbench
